// ### design/decoder_pkg.sv
`default_nettype none
package decoder_pkg;

	// ------------------------------------------------------------
	// instruction word layout
	// ------------------------------------------------------------
	localparam int INSTR_W = 16;
	localparam int MODE_BIT = 15;
	localparam int MAJ_HI = 14;
	localparam int MAJ_LO = 11;
	localparam int ROW_HI = 10;
	localparam int ROW_LO = 8;
	localparam int COL_HI = 7;
	localparam int COL_LO = 4;
	localparam int LOW_HI = 3;
	localparam int LOW_LO = 0;
	localparam int ADDR_W = 11;
	localparam int PC_W = 14;
	localparam int PAGE_W = 2;

	// ------------------------------------------------------------
	// major operation codes, bits 14 to 11
	// ------------------------------------------------------------
	localparam logic [3:0] MAJ_ADD = 4'h0;
	localparam logic [3:0] MAJ_SUB = 4'h1;
	localparam logic [3:0] MAJ_ADD_CARRY = 4'h2;
	localparam logic [3:0] MAJ_SUB_BORROW = 4'h3;
	localparam logic [3:0] MAJ_AND = 4'h4;
	localparam logic [3:0] MAJ_XOR = 4'h5;
	localparam logic [3:0] MAJ_OR = 4'h6;
	localparam logic [3:0] MAJ_MISC = 4'h7;
	localparam logic [3:0] MAJ_LOAD_STORE = 4'h8;
	localparam logic [3:0] MAJ_EQ_GE = 4'h9;
	localparam logic [3:0] MAJ_MOV_IND = 4'hA;
	localparam logic [3:0] MAJ_NE_LT = 4'hB;
	localparam logic [3:0] MAJ_PAGE0 = 4'hC;
	localparam logic [3:0] MAJ_PAGE1 = 4'hD;
	localparam logic [3:0] MAJ_PAGE2 = 4'hE;
	localparam logic [3:0] MAJ_PAGE3 = 4'hF;

	// ------------------------------------------------------------
	// miscellaneous group sub-codes, bits 7 to 4
	// ------------------------------------------------------------
	localparam logic [3:0] SUB_TABLE_READ = 4'h1;
	localparam logic [3:0] SUB_POKE = 4'h2;
	localparam logic [3:0] SUB_PEEK = 4'h3;
	localparam logic [3:0] SUB_JUMP_IND = 4'h4;
	localparam logic [3:0] SUB_CALL_IND = 4'h5;
	localparam logic [3:0] SUB_SYSTEM_CALL = 4'h6;
	localparam logic [3:0] SUB_ROTATE = 4'h7;
	localparam logic [3:0] SUB_INC_INDEX = 4'h8;
	localparam logic [3:0] SUB_INC_TABLE = 4'h9;
	localparam logic [3:0] SUB_GET = 4'hA;
	localparam logic [3:0] SUB_PUT = 4'hB;
	localparam logic [3:0] SUB_POP = 4'hC;
	localparam logic [3:0] SUB_PUSH = 4'hD;
	localparam logic [3:0] SUB_CONTROL = 4'hE;
	// control sub-group, bits 3 to 0
	localparam logic [3:0] CTL_RETURN = 4'h0;
	localparam logic [3:0] CTL_RETURN_SKIP = 4'h1;
	localparam logic [3:0] CTL_INT_RETURN = 4'h2;
	localparam logic [3:0] CTL_INT_ENABLE = 4'h3;
	localparam logic [3:0] CTL_INT_MASK = 4'h4;
	localparam logic [3:0] CTL_STOP = 4'h5;
	localparam logic [3:0] CTL_HALT = 4'h6;
	localparam logic [3:0] CTL_NOP = 4'h7;
	localparam logic [2:0] ROW_ZERO = 3'h0;
	localparam logic [3:0] LOW_ZERO = 4'h0;

	// ------------------------------------------------------------
	// address stack
	// ------------------------------------------------------------
	localparam int STACK_PTR_W = 3;
	localparam logic [STACK_PTR_W-1:0] STACK_PTR_RESET = 3'h7;

	typedef enum logic [5:0] {
		op_nop, op_add, op_sub, op_add_with_carry, op_subtract_with_borrow,
		op_and, op_xor, op_or, op_load, op_store,
		op_skip_if_equal, op_skip_greater_equal, op_skip_not_equal, op_skip_less_than,
		op_mov_to_indirect, op_mov_from_indirect, op_jump_instr, op_call, op_mov_imm,
		op_skip_bits_all_set, op_skip_bits_all_clear,
		op_inc_table, op_inc_index, op_rotate_right_carry, op_table_read,
		op_push, op_pop, op_get, op_put, op_peek, op_poke,
		op_jump_indirect, op_call_indirect, op_system_call, op_return,
		op_return_and_skip, op_interrupt_return, op_interrupt_enable_instr,
		op_interrupt_mask_instr, op_stop, op_halt, op_interrupt_entry
	} op_type;

	typedef enum logic [2:0] {
		alu_none, alu_add, alu_sub, alu_and, alu_xor, alu_or, alu_pass
	} alu_type;

	typedef enum logic [2:0] {
		skip_none, skip_zero, skip_nonzero, skip_no_borrow, skip_borrow,
		skip_all_set, skip_all_clear
	} skip_type;

	typedef struct packed {
		op_type op;
		alu_type alu;
		skip_type skip_cond;
		logic use_carry;
		logic writes_reg;
		logic writes_mem;
		logic uses_imm;
		logic stack_push;
		logic stack_pop;
		logic save_interrupt_saved_reg;
		logic [STACK_PTR_W-1:0] stack_entry;
		logic [2:0] mem_row;
		logic [3:0] mem_col;
		logic [3:0] reg_col;
		logic [3:0] imm;
		logic [3:0] bit_sel;
		logic [2:0] periph_hi;
		logic [3:0] periph_lo;
		logic [2:0] rf_row;
		logic [3:0] rf_col;
		logic [2:0] entry_hi;
		logic [3:0] entry_lo;
		logic [PC_W-1:0] jump_target;
	} decode_type;

endpackage
`default_nettype wire

// ### design/nibble_cpu_instruction_decoder.sv
`default_nettype none
module nibble_cpu_instruction_decoder (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic instr_valid,
	input wire logic [decoder_pkg::INSTR_W-1:0] instr,
	input wire logic take_interrupt,
	input wire logic segment_bit_reg,
	output logic instr_ready,
	output logic dec_valid,
	output decoder_pkg::decode_type dec
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic is_push(input decoder_pkg::op_type op);
		is_push = (op == decoder_pkg::op_push) || (op == decoder_pkg::op_call) ||
			(op == decoder_pkg::op_call_indirect) || (op == decoder_pkg::op_system_call) ||
			(op == decoder_pkg::op_interrupt_entry);
	endfunction

	function automatic logic is_pop(input decoder_pkg::op_type op);
		is_pop = (op == decoder_pkg::op_pop) || (op == decoder_pkg::op_return) ||
			(op == decoder_pkg::op_return_and_skip) ||
			(op == decoder_pkg::op_interrupt_return);
	endfunction

	function automatic decoder_pkg::alu_type alu_of(input logic [3:0] maj);
		case (maj)
			decoder_pkg::MAJ_ADD, decoder_pkg::MAJ_ADD_CARRY: alu_of = decoder_pkg::alu_add;
			decoder_pkg::MAJ_SUB, decoder_pkg::MAJ_SUB_BORROW: alu_of = decoder_pkg::alu_sub;
			decoder_pkg::MAJ_AND: alu_of = decoder_pkg::alu_and;
			decoder_pkg::MAJ_XOR: alu_of = decoder_pkg::alu_xor;
			decoder_pkg::MAJ_OR: alu_of = decoder_pkg::alu_or;
			default: alu_of = decoder_pkg::alu_none;
		endcase
	endfunction

	function automatic decoder_pkg::op_type arith_op(input logic [3:0] maj);
		case (maj)
			decoder_pkg::MAJ_ADD: arith_op = decoder_pkg::op_add;
			decoder_pkg::MAJ_SUB: arith_op = decoder_pkg::op_sub;
			decoder_pkg::MAJ_ADD_CARRY: arith_op = decoder_pkg::op_add_with_carry;
			decoder_pkg::MAJ_SUB_BORROW: arith_op = decoder_pkg::op_subtract_with_borrow;
			decoder_pkg::MAJ_AND: arith_op = decoder_pkg::op_and;
			decoder_pkg::MAJ_XOR: arith_op = decoder_pkg::op_xor;
			default: arith_op = decoder_pkg::op_or;
		endcase
	endfunction

	logic accept;
	logic [3:0] maj;
	logic mode;
	logic [2:0] row;
	logic [3:0] col;
	logic [3:0] low;
	logic [decoder_pkg::STACK_PTR_W-1:0] stack_pointer;
	logic next_dec_valid;
	decoder_pkg::decode_type next_dec;
	decoder_pkg::op_type op;

	// ------------------------------------------------------------
	// field split
	// ------------------------------------------------------------
	// interrupt entry takes the slot, so the word waits one cycle
	assign instr_ready = ce && !take_interrupt;
	assign accept = instr_valid && instr_ready;
	assign mode = instr[decoder_pkg::MODE_BIT];
	assign maj = instr[decoder_pkg::MAJ_HI:decoder_pkg::MAJ_LO];
	assign row = instr[decoder_pkg::ROW_HI:decoder_pkg::ROW_LO];
	assign col = instr[decoder_pkg::COL_HI:decoder_pkg::COL_LO];
	assign low = instr[decoder_pkg::LOW_HI:decoder_pkg::LOW_LO];

	// ------------------------------------------------------------
	// operation select
	// ------------------------------------------------------------
	always_comb begin
		op = decoder_pkg::op_nop;
		case (maj)
			decoder_pkg::MAJ_MISC: begin
				case (col)
					decoder_pkg::SUB_TABLE_READ: if (row == decoder_pkg::ROW_ZERO &&
						low == decoder_pkg::LOW_ZERO) op = decoder_pkg::op_table_read;
					decoder_pkg::SUB_INC_TABLE: if (row == decoder_pkg::ROW_ZERO &&
						low == decoder_pkg::LOW_ZERO) op = decoder_pkg::op_inc_table;
					decoder_pkg::SUB_INC_INDEX: if (row == decoder_pkg::ROW_ZERO &&
						low == decoder_pkg::LOW_ZERO) op = decoder_pkg::op_inc_index;
					decoder_pkg::SUB_PUSH: if (row == decoder_pkg::ROW_ZERO &&
						low == decoder_pkg::LOW_ZERO) op = decoder_pkg::op_push;
					decoder_pkg::SUB_POP: if (row == decoder_pkg::ROW_ZERO &&
						low == decoder_pkg::LOW_ZERO) op = decoder_pkg::op_pop;
					decoder_pkg::SUB_JUMP_IND: if (row == decoder_pkg::ROW_ZERO &&
						low == decoder_pkg::LOW_ZERO) op = decoder_pkg::op_jump_indirect;
					decoder_pkg::SUB_CALL_IND: if (row == decoder_pkg::ROW_ZERO &&
						low == decoder_pkg::LOW_ZERO) op = decoder_pkg::op_call_indirect;
					decoder_pkg::SUB_ROTATE: if (row == decoder_pkg::ROW_ZERO)
						op = decoder_pkg::op_rotate_right_carry;
					decoder_pkg::SUB_GET: op = decoder_pkg::op_get;
					decoder_pkg::SUB_PUT: op = decoder_pkg::op_put;
					decoder_pkg::SUB_PEEK: op = decoder_pkg::op_peek;
					decoder_pkg::SUB_POKE: op = decoder_pkg::op_poke;
					decoder_pkg::SUB_SYSTEM_CALL: op = decoder_pkg::op_system_call;
					decoder_pkg::SUB_CONTROL: begin
						if (row == decoder_pkg::ROW_ZERO) begin
							case (low)
								decoder_pkg::CTL_RETURN: op = decoder_pkg::op_return;
								decoder_pkg::CTL_RETURN_SKIP: op = decoder_pkg::op_return_and_skip;
								decoder_pkg::CTL_INT_RETURN: op = decoder_pkg::op_interrupt_return;
								decoder_pkg::CTL_INT_ENABLE: op = decoder_pkg::op_interrupt_enable_instr;
								decoder_pkg::CTL_INT_MASK: op = decoder_pkg::op_interrupt_mask_instr;
								decoder_pkg::CTL_STOP: op = decoder_pkg::op_stop;
								decoder_pkg::CTL_HALT: op = decoder_pkg::op_halt;
								default: op = decoder_pkg::op_nop;
							endcase
						end
					end
					default: op = decoder_pkg::op_nop;
				endcase
			end
			decoder_pkg::MAJ_LOAD_STORE: op = mode ? decoder_pkg::op_store : decoder_pkg::op_load;
			decoder_pkg::MAJ_EQ_GE: op = mode ? decoder_pkg::op_skip_greater_equal :
				decoder_pkg::op_skip_if_equal;
			decoder_pkg::MAJ_NE_LT: op = mode ? decoder_pkg::op_skip_less_than :
				decoder_pkg::op_skip_not_equal;
			decoder_pkg::MAJ_MOV_IND: op = mode ? decoder_pkg::op_mov_from_indirect :
				decoder_pkg::op_mov_to_indirect;
			decoder_pkg::MAJ_PAGE0: op = mode ? decoder_pkg::op_call : decoder_pkg::op_jump_instr;
			decoder_pkg::MAJ_PAGE1: op = mode ? decoder_pkg::op_mov_imm : decoder_pkg::op_jump_instr;
			decoder_pkg::MAJ_PAGE2: op = mode ? decoder_pkg::op_skip_bits_all_set :
				decoder_pkg::op_jump_instr;
			decoder_pkg::MAJ_PAGE3: op = mode ? decoder_pkg::op_skip_bits_all_clear :
				decoder_pkg::op_jump_instr;
			default: op = arith_op(maj);
		endcase
	end

	// ------------------------------------------------------------
	// control bundle
	// ------------------------------------------------------------
	always_comb begin
		next_dec = dec;
		next_dec_valid = 1'b0;
		if (ce && take_interrupt) begin
			next_dec = '0;
			next_dec.op = decoder_pkg::op_interrupt_entry;
			next_dec.save_interrupt_saved_reg = 1'b1;
			next_dec.stack_push = 1'b1;
			next_dec.stack_entry = stack_pointer - 1'b1;
			next_dec_valid = 1'b1;
		end else if (accept) begin
			next_dec = '0;
			next_dec_valid = 1'b1;
			next_dec.op = op;
			next_dec.mem_row = row;
			next_dec.mem_col = col;
			next_dec.reg_col = low;
			next_dec.imm = low;
			next_dec.bit_sel = low;
			next_dec.periph_hi = row;
			next_dec.periph_lo = low;
			next_dec.rf_row = row;
			next_dec.rf_col = low;
			next_dec.entry_hi = row;
			next_dec.entry_lo = low;
			// page 0 for calls, opcode low bits for jumps
			next_dec.jump_target = {segment_bit_reg,
				(mode ? 2'h0 : maj[decoder_pkg::PAGE_W-1:0]),
				instr[decoder_pkg::ADDR_W-1:0]};
			next_dec.stack_push = is_push(op);
			next_dec.stack_pop = is_pop(op);
			next_dec.stack_entry = is_push(op) ? stack_pointer - 1'b1 : stack_pointer;
			if (maj < decoder_pkg::MAJ_MISC) begin
				next_dec.alu = alu_of(maj);
				next_dec.use_carry = (maj == decoder_pkg::MAJ_ADD_CARRY) ||
					(maj == decoder_pkg::MAJ_SUB_BORROW);
				next_dec.writes_reg = !mode;
				next_dec.writes_mem = mode;
				next_dec.uses_imm = mode;
			end
			case (op)
				decoder_pkg::op_load: begin
					next_dec.alu = decoder_pkg::alu_pass;
					next_dec.writes_reg = 1'b1;
				end
				decoder_pkg::op_store, decoder_pkg::op_mov_from_indirect: begin
					next_dec.alu = decoder_pkg::alu_pass;
					next_dec.writes_mem = 1'b1;
				end
				decoder_pkg::op_mov_to_indirect: begin
					next_dec.alu = decoder_pkg::alu_pass;
					next_dec.writes_reg = 1'b1;
				end
				decoder_pkg::op_mov_imm: begin
					next_dec.alu = decoder_pkg::alu_pass;
					next_dec.writes_mem = 1'b1;
					next_dec.uses_imm = 1'b1;
				end
				// compare: subtract, result dropped
				decoder_pkg::op_skip_if_equal, decoder_pkg::op_skip_not_equal,
				decoder_pkg::op_skip_greater_equal, decoder_pkg::op_skip_less_than: begin
					next_dec.alu = decoder_pkg::alu_sub;
					next_dec.uses_imm = 1'b1;
					case (op)
						decoder_pkg::op_skip_if_equal: next_dec.skip_cond = decoder_pkg::skip_zero;
						decoder_pkg::op_skip_not_equal: next_dec.skip_cond = decoder_pkg::skip_nonzero;
						decoder_pkg::op_skip_greater_equal:
							next_dec.skip_cond = decoder_pkg::skip_no_borrow;
						default: next_dec.skip_cond = decoder_pkg::skip_borrow;
					endcase
				end
				decoder_pkg::op_skip_bits_all_set: next_dec.skip_cond = decoder_pkg::skip_all_set;
				decoder_pkg::op_skip_bits_all_clear: next_dec.skip_cond = decoder_pkg::skip_all_clear;
				decoder_pkg::op_rotate_right_carry, decoder_pkg::op_get,
				decoder_pkg::op_peek: next_dec.writes_reg = (op == decoder_pkg::op_rotate_right_carry);
				default: next_dec.alu = next_dec.alu;
			endcase
		end
	end

	// register only; frozen while ce is low
	always_ff @(posedge clk) begin
		if (rst) begin
			dec_valid <= 1'b0;
			dec <= '0;
		end else if (ce) begin
			dec_valid <= next_dec_valid;
			dec <= next_dec;
		end
	end

	// ------------------------------------------------------------
	// address stack pointer
	// ------------------------------------------------------------
	stack_pointer_unit stack_unit (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.push(next_dec_valid && next_dec.stack_push),
		.pop(next_dec_valid && next_dec.stack_pop),
		.stack_pointer(stack_pointer)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	alu_reg_a: assert property (accept && !mode && maj < decoder_pkg::MAJ_MISC |=>
		dec_valid && dec.writes_reg && !dec.writes_mem && dec.alu != decoder_pkg::alu_none)
		else $error("register alu decode wrong");
	alu_mem_a: assert property (accept && mode && maj == decoder_pkg::MAJ_ADD_CARRY |=>
		dec.op == decoder_pkg::op_add_with_carry && dec.use_carry && dec.writes_mem && dec.uses_imm)
		else $error("immediate alu decode wrong");
	load_store_a: assert property (accept && maj == decoder_pkg::MAJ_LOAD_STORE |=>
		dec.writes_mem == $past(mode) && dec.writes_reg == !$past(mode))
		else $error("load store direction wrong");
	compare_skip_a: assert property (accept && maj == decoder_pkg::MAJ_NE_LT && mode |=>
		dec.skip_cond == decoder_pkg::skip_borrow && dec.alu == decoder_pkg::alu_sub &&
		!dec.writes_mem) else $error("compare skip decode wrong");
	indirect_move_a: assert property (accept && maj == decoder_pkg::MAJ_MOV_IND |=>
		dec.writes_mem == $past(mode)) else $error("indirect move direction wrong");
	jump_target_a: assert property (accept && !mode && maj[3:2] == 2'h3 |=>
		dec.op == decoder_pkg::op_jump_instr &&
		dec.jump_target == {$past(segment_bit_reg), $past(maj[1:0]), $past(instr[10:0])})
		else $error("jump target wrong");
	call_page_a: assert property (accept && mode && maj == decoder_pkg::MAJ_PAGE0 |=>
		dec.op == decoder_pkg::op_call && dec.jump_target[12:11] == 2'h0 && dec.stack_push)
		else $error("call decode wrong");
	unknown_nop_a: assert property (accept && maj == decoder_pkg::MAJ_MISC &&
		col == 4'hF |=> dec.op == decoder_pkg::op_nop && !dec.writes_mem && !dec.writes_reg)
		else $error("unknown word not nop");
	interrupt_save_a: assert property (ce && take_interrupt |-> !instr_ready ##1
		(dec_valid && dec.save_interrupt_saved_reg && dec.stack_entry == $past(stack_pointer) - 3'h1))
		else $error("interrupt save missing");
	stack_entry_a: assert property (accept && is_pop(op) && !take_interrupt |=>
		dec.stack_entry == $past(stack_pointer) && stack_pointer == $past(stack_pointer) + 3'h1)
		else $error("stack entry wrong");
	fields_a: assert property (accept |=> dec.periph_hi == $past(instr[10:8]) &&
		dec.rf_col == $past(instr[3:0]) && dec.mem_col == $past(instr[7:4]))
		else $error("operand fields wrong");

endmodule // nibble_cpu_instruction_decoder
`default_nettype wire

// ### design/stack_pointer_unit.sv
`default_nettype none
module stack_pointer_unit (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic push,
	input wire logic pop,
	output logic [decoder_pkg::STACK_PTR_W-1:0] stack_pointer
);

	logic [decoder_pkg::STACK_PTR_W-1:0] next_stack_pointer;

	// ------------------------------------------------------------
	// pointer update
	// ------------------------------------------------------------
	// push moves down first, pop moves up after the read; both at once cancel
	always_comb begin
		next_stack_pointer = stack_pointer;
		if (push && !pop) begin
			next_stack_pointer = stack_pointer - 1'b1;
		end else if (pop && !push) begin
			next_stack_pointer = stack_pointer + 1'b1;
		end
	end

	// register only; wraps silently, overflow is a software fault
	always_ff @(posedge clk) begin
		if (rst) begin
			stack_pointer <= decoder_pkg::STACK_PTR_RESET;
		end else if (ce) begin
			stack_pointer <= next_stack_pointer;
		end
	end

endmodule // stack_pointer_unit
`default_nettype wire

// ### dv/nibble_cpu_instruction_decoder_tb_top.sv
`default_nettype none
module nibble_cpu_instruction_decoder_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------
	// clock, reset and wiring
	// ------------------------------------------------------------
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic take_interrupt = 1'b0;
	logic segment_bit_reg = 1'b0;
	logic instr_valid;
	logic instr_ready;
	logic dec_valid;
	logic [decoder_pkg::INSTR_W-1:0] instr;
	decoder_pkg::decode_type dec;
	int failures = 0;
	int total_checks = 0;
	// 50 MHz core clock
	always #10 clk = ~clk;
	nibble_cpu_instruction_decoder dut_u (.clk(clk), .rst(rst), .ce(ce), .instr_valid(instr_valid),
		.instr(instr), .take_interrupt(take_interrupt), .segment_bit_reg(segment_bit_reg),
		.instr_ready(instr_ready), .dec_valid(dec_valid), .dec(dec));
	program_memory_model mem_u (.clk(clk), .instr_ready(instr_ready), .instr_valid(instr_valid),
		.instr(instr));
	// verdict, also reached when a wait runs out
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// one counted comparison
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// offer a word; its decode must stand right after the taking edge
	task automatic issue(input logic [15:0] w);
		bit ok;
		mem_u.offer(w, ok);
		check(32'(ok), 32'h1);
		if (!ok) begin
			end_of_test();
		end else begin
			check(32'(dec_valid), 32'h1);
		end
	endtask
	// expected operation; code 7 words here carry sub-code A, a peripheral get in any row
	function automatic logic [31:0] exp_op(input logic m, input logic [3:0] c);
		case (c)
			4'h7: return 32'(decoder_pkg::op_get);
			4'h8: return 32'(decoder_pkg::op_load) + 32'(m);
			4'h9: return 32'(decoder_pkg::op_skip_if_equal) + 32'(m);
			4'hA: return 32'(decoder_pkg::op_mov_to_indirect) + 32'(m);
			4'hB: return 32'(decoder_pkg::op_skip_not_equal) + 32'(m);
			default: begin
				if (c < 4'h7) begin
					return 32'(decoder_pkg::op_add) + 32'(c);
				end
				return m ? 32'(decoder_pkg::op_call) + 32'(c) - 32'hC : 32'(decoder_pkg::op_jump_instr);
			end
		endcase
	endfunction
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	// stack entries for push, pop and interrupt entry; interrupt beats a word
	task automatic test_stack;
		bit ok;
		issue(16'h38D0);
		check(dec.op, decoder_pkg::op_push);
		check({dec.stack_push, dec.stack_entry}, 4'hE);
		issue(16'h38C0);
		check(dec.op, decoder_pkg::op_pop);
		check({dec.stack_pop, dec.stack_entry}, 4'hE);
		fork
			mem_u.offer(16'h0000, ok);
			// request lasts one cycle only; a second cycle would be a second entry
			begin
				@(negedge clk);
				take_interrupt = 1'b1;
				@(negedge clk);
				check(dec_valid, 1'b1);
				check(dec.op, decoder_pkg::op_interrupt_entry);
				check({dec.save_interrupt_saved_reg, dec.stack_push, dec.stack_entry}, 5'h1E);
				take_interrupt = 1'b0;
			end
		join
		check(32'(ok), 32'h1);
		check(dec.op, decoder_pkg::op_add);
		$display("stack test done");
	endtask
	// miscellaneous group sub-codes and the control sub-group
	task automatic test_misc;
		logic [15:0] w [12] = '{16'h3890, 16'h3880, 16'h3875, 16'h3810, 16'h3DA9,
			16'h3DB9, 16'h3A39, 16'h3A29, 16'h3E6C, 16'h3840, 16'h3850, 16'h38F0};
		decoder_pkg::op_type o [12] = '{decoder_pkg::op_inc_table, decoder_pkg::op_inc_index,
			decoder_pkg::op_rotate_right_carry, decoder_pkg::op_table_read, decoder_pkg::op_get,
			decoder_pkg::op_put, decoder_pkg::op_peek, decoder_pkg::op_poke,
			decoder_pkg::op_system_call, decoder_pkg::op_jump_indirect,
			decoder_pkg::op_call_indirect, decoder_pkg::op_nop};
		for (int k = 0; k < 12; k++) begin
			issue(w[k]);
			check(dec.op, o[k]);
		end
		for (int k = 0; k < 8; k++) begin
			issue(16'h38E0 | 16'(k));
			check(dec.op, k == 7 ? 32'(decoder_pkg::op_nop) : 32'(decoder_pkg::op_return) + 32'(k));
		end
		$display("misc test done");
	endtask
	// all 32 opcodes with fixed operand fields; segment bit toggles
	task automatic test_map;
		logic [4:0] i;
		for (int k = 0; k < 32; k++) begin
			i = 5'(k);
			segment_bit_reg = i[0];
			issue({i, 11'h5A3});
			check(dec.op, exp_op(i[4], i[3:0]));
			check({dec.mem_row, dec.mem_col, dec.imm, dec.bit_sel, dec.reg_col}, 19'h5A333);
			check({dec.periph_hi, dec.periph_lo, dec.rf_row, dec.rf_col, dec.entry_hi, dec.entry_lo},
				21'h14E9D3);
			if (i[3:0] < 4'h7) begin
				check(dec.writes_mem, i[4]);
			end
			if (i[3:0] == 4'h9 || i[3:0] == 4'hB) begin
				check(dec.skip_cond, i[1] ? (i[4] ? 3'h4 : 3'h2) : (i[4] ? 3'h3 : 3'h1));
				check(dec.writes_mem, 1'b0);
			end
			if (i[3:2] == 2'b11 && (!i[4] || i[1:0] == 2'b00)) begin
				check(dec.jump_target, {i[0], i[4] ? 2'b00 : i[1:0], 11'h5A3});
			end
		end
		$display("map test done");
	endtask
	// clock enable low: word refused and held, then taken
	task automatic test_hold;
		bit ok;
		// one idle cycle first, so the frozen valid is low
		@(negedge clk);
		ce = 1'b0;
		fork
			mem_u.offer(16'h1000, ok);
			begin
				repeat (4) @(negedge clk);
				check(dec_valid, 1'b0);
				check(instr_ready, 1'b0);
				check(dec.op, decoder_pkg::op_skip_bits_all_clear);
				ce = 1'b1;
			end
		join
		check(32'(ok), 32'h1);
		check(dec.op, decoder_pkg::op_add_with_carry);
		$display("hold test done");
	endtask
	// main sequence
	initial begin
		repeat (8) @(negedge clk);
		rst = 1'b0;
		check(dec_valid, 1'b0);
		check(dec.op, decoder_pkg::op_nop);
		test_stack();
		test_misc();
		test_map();
		test_hold();
		end_of_test();
	end
	// run-length ceiling
	initial begin
		#200000;
		failures++;
		end_of_test();
	end
endmodule // nibble_cpu_instruction_decoder_tb_top
`default_nettype wire

// ### dv/program_memory_model.sv
`default_nettype none
module program_memory_model (
	input wire logic clk,
	input wire logic instr_ready,
	output logic instr_valid,
	output logic [decoder_pkg::INSTR_W-1:0] instr
);
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------
	// instruction word source
	// ------------------------------------------------------------
	// idle bus shows nothing useful
	initial begin
		instr_valid = 1'b0;
		instr = 16'h0000;
	end
	// word held until taken or for 50 cycles; idle bus then shows the inverse, never a stale copy
	task automatic offer(input logic [15:0] w, output bit ok);
		ok = 1'b0;
		@(negedge clk);
		instr_valid = 1'b1;
		instr = w;
		for (int n = 0; n < 50 && !ok; n++) begin
			@(posedge clk);
			ok = instr_ready;
		end
		@(negedge clk);
		instr_valid = 1'b0;
		instr = ~w;
	endtask
endmodule // program_memory_model
`default_nettype wire
